// ===== include/ccsu_consts.svh
// constants of the common command and status unit
// Notes on behaviour
// RULE1: identification answers maker, model, serial, firmware text
// RULE2: reset command restores functional settings to defaults
// RULE3: self-test query returns 0 pass, 1 fail
// RULE4: event enable mask written 0-255, stored 8 bits
// RULE5: standard event register records eight condition kinds
// RULE6: masked standard events ORed into status bit 5
// RULE7: reset command leaves event enable mask unchanged
// RULE8: event enable query returns stored mask
// RULE9: standard event query returns register, 0-255
// RULE10: complete command sets event bit 0 when idle
// RULE11: complete query answers ASCII 1 once idle
// RULE12: no new command while complete query waits
// RULE13: request enable stored with bit 6 clear
// RULE14: request enable query returns stored mask
// RULE15: status byte query alters no status bit
// RULE16: power-on clear flag clears enables at power-on
// RULE17: power-on clear query returns flag 0 or 1
// RULE18: clear-status empties queue and all event registers
// RULE19: questionable event register 16 bits, read clears
// RULE20: questionable and operation enables are 16-bit masks
// RULE21: standard event query clears register after reading
// RULE22: status bit 6 summarises enabled other bits
`ifndef CCSU_CONSTS_SVH
`define CCSU_CONSTS_SVH

`define CCSU_CMD_W      5
`define CCSU_CMD_IDN    5'h00
`define CCSU_CMD_RST    5'h01
`define CCSU_CMD_TST    5'h02
`define CCSU_CMD_ESE_W  5'h03
`define CCSU_CMD_ESE_R  5'h04
`define CCSU_CMD_ESR_R  5'h05
`define CCSU_CMD_OPC    5'h06
`define CCSU_CMD_OPC_Q  5'h07
`define CCSU_CMD_SRE_W  5'h08
`define CCSU_CMD_SRE_R  5'h09
`define CCSU_CMD_STB_R  5'h0A
`define CCSU_CMD_PSC_W  5'h0B
`define CCSU_CMD_PSC_R  5'h0C
`define CCSU_CMD_CLS    5'h0D
`define CCSU_CMD_QEV_R  5'h0E
`define CCSU_CMD_QEN_W  5'h0F
`define CCSU_CMD_QEN_R  5'h10
`define CCSU_CMD_OEV_R  5'h11
`define CCSU_CMD_OEN_W  5'h12
`define CCSU_CMD_OEN_R  5'h13

`define CCSU_ESR_OPC    0
`define CCSU_ESR_RQC    1
`define CCSU_ESR_QYE    2
`define CCSU_ESR_DDE    3
`define CCSU_ESR_EXE    4
`define CCSU_ESR_CME    5
`define CCSU_ESR_URQ    6
`define CCSU_ESR_PON    7

`define CCSU_STB_EAV    2
`define CCSU_STB_QSB    3
`define CCSU_STB_ESB    5
`define CCSU_STB_MSS    6
`define CCSU_STB_OSB    7

`define CCSU_SRE_MASK   8'hBF
`define CCSU_ASCII_ONE  8'h31
`define CCSU_PSC_RESET  1'h1

`endif

// ===== include/ccsu_pkg.sv
// types of the common command and status unit
`include "ccsu_consts.svh"
package ccsu_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_IDN  = 3'h2,
    ST_OPCW = 3'h4
  } ccsu_state_type;

  typedef struct packed {
    logic                   valid;
    logic [`CCSU_CMD_W-1:0] code;
    logic [15:0]            data;
  } ccsu_cmd_type;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] data;
  } ccsu_rsp_type;

  typedef struct packed {
    logic power_on;
    logic user_req;
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic query_err;
    logic req_ctrl;
  } ccsu_event_type;

  typedef struct packed {
    ccsu_state_type state;
    logic [7:0]     idx;
    logic           ready;
    ccsu_rsp_type   rsp;
    logic           func_rst;
    logic           eq_clr;
    logic           opc_armed;
    logic           tst_done;
    logic           tst_fail;
    logic           psc;
    logic [7:0]     ese;
    logic [7:0]     esr;
    logic [7:0]     sre;
    logic [7:0]     stb;
    logic           srq;
    logic [15:0]    qev;
    logic [15:0]    qen;
    logic [15:0]    oev;
    logic [15:0]    oen;
  } ccsu_regs_type;

endpackage

// ===== core/ccsu_core.sv
// common command interpreter and status reporting core
`timescale 1ns/1ps
`include "ccsu_consts.svh"
module ccsu_core
#(
  parameter int               IDN_LEN  = 22,
  // identification text; value is arbitrary
  parameter logic [8*22-1:0]  IDN_TEXT = "ACME,CCSU,00000000,1.0"
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire ccsu_pkg::ccsu_cmd_type cmd,
  input  wire ccsu_pkg::ccsu_event_type ev,
  input  wire logic                   op_busy,
  input  wire logic                   self_test_fail,
  input  wire logic                   err_queue_nonempty,
  input  wire logic [15:0]            ques_set,
  input  wire logic [15:0]            oper_set,
  output      logic                   cmd_ready,
  output      ccsu_pkg::ccsu_rsp_type rsp,
  output      logic                   func_reset,
  output      logic                   err_queue_clear,
  output      logic [7:0]             summary_status_byte,
  output      logic                   service_request
);

  localparam ccsu_pkg::ccsu_regs_type REGS_RESET = '{
    state     : ccsu_pkg::ST_IDLE,
    idx       : 8'h00,
    ready     : 1'h0,
    rsp       : '{valid: 1'h0, last: 1'h0, data: 16'h0000},
    func_rst  : 1'h0,
    eq_clr    : 1'h0,
    opc_armed : 1'h0,
    tst_done  : 1'h0,
    tst_fail  : 1'h0,
    psc       : `CCSU_PSC_RESET,
    ese       : 8'h00,
    esr       : 8'h00,
    sre       : 8'h00,
    stb       : 8'h00,
    srq       : 1'h0,
    qev       : 16'h0000,
    qen       : 16'h0000,
    oev       : 16'h0000,
    oen       : 16'h0000
  };

  ccsu_pkg::ccsu_regs_type r_reg;
  ccsu_pkg::ccsu_regs_type r_next;

  // identification byte at a given position of the text
  function automatic logic [7:0] idn_byte(input logic [7:0] i);
    idn_byte = IDN_TEXT[8*(IDN_LEN-1-int'(i)) +: 8];
  endfunction

  logic       take;
  logic [7:0] esr_set;
  logic       esr_clr;
  logic       qev_clr;
  logic       oev_clr;
  logic [7:0] stb_low;

  assign take = cmd.valid && r_reg.ready;

  always_comb
  begin
    r_next          = r_reg;
    r_next.rsp      = '{valid: 1'h0, last: 1'h0, data: 16'h0000};
    r_next.func_rst = 1'h0;
    r_next.eq_clr   = 1'h0;
    esr_set         = 8'h00;
    esr_clr         = 1'h0;
    qev_clr         = 1'h0;
    oev_clr         = 1'h0;
    stb_low         = 8'h00;

    // strap is caught on the first enabled cycle after release
    if (!r_reg.tst_done)
    begin
      r_next.tst_done = 1'h1;
      r_next.tst_fail = self_test_fail;
    end

    case (r_reg.state)
      ccsu_pkg::ST_IDLE:
      begin
        if (take)
        begin
          case (cmd.code)
            `CCSU_CMD_IDN:
            begin
              r_next.state = ccsu_pkg::ST_IDN; // see RULE1
              r_next.idx   = 8'h00;
            end
            `CCSU_CMD_RST:
              r_next.func_rst = 1'h1; // see RULE2 see RULE7
            `CCSU_CMD_TST:
            begin
              r_next.rsp.valid = 1'h1; // see RULE3
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = {15'h0000, r_reg.tst_fail};
            end
            `CCSU_CMD_ESE_W:
              r_next.ese = cmd.data[7:0]; // see RULE4
            `CCSU_CMD_ESE_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE8
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = {8'h00, r_reg.ese};
            end
            `CCSU_CMD_ESR_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE9
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = {8'h00, r_reg.esr};
              esr_clr          = 1'h1; // see RULE21
            end
            `CCSU_CMD_OPC:
              r_next.opc_armed = 1'h1; // see RULE10
            `CCSU_CMD_OPC_Q:
              r_next.state = ccsu_pkg::ST_OPCW; // see RULE11
            `CCSU_CMD_SRE_W:
              r_next.sre = cmd.data[7:0] & `CCSU_SRE_MASK; // see RULE13
            `CCSU_CMD_SRE_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE14
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = {8'h00, r_reg.sre};
            end
            `CCSU_CMD_STB_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE15
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = {8'h00, r_reg.stb};
            end
            `CCSU_CMD_PSC_W:
              r_next.psc = cmd.data[0]; // see RULE16
            `CCSU_CMD_PSC_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE17
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = {15'h0000, r_reg.psc};
            end
            `CCSU_CMD_CLS:
            begin
              r_next.eq_clr    = 1'h1; // see RULE18
              r_next.opc_armed = 1'h0;
              esr_clr          = 1'h1;
              qev_clr          = 1'h1;
              oev_clr          = 1'h1;
            end
            `CCSU_CMD_QEV_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE19
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = r_reg.qev;
              qev_clr          = 1'h1;
            end
            `CCSU_CMD_QEN_W:
              r_next.qen = cmd.data; // see RULE20
            `CCSU_CMD_QEN_R:
            begin
              r_next.rsp.valid = 1'h1; // see RULE20
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = r_reg.qen;
            end
            `CCSU_CMD_OEV_R:
            begin
              r_next.rsp.valid = 1'h1;
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = r_reg.oev;
            end
            `CCSU_CMD_OEN_W:
              r_next.oen = cmd.data; // see RULE20
            `CCSU_CMD_OEN_R:
            begin
              r_next.rsp.valid = 1'h1;
              r_next.rsp.last  = 1'h1;
              r_next.rsp.data  = r_reg.oen;
            end
            default:
              esr_set[`CCSU_ESR_CME] = 1'h1;
          endcase
        end
      end
      ccsu_pkg::ST_IDN:
      begin
        r_next.rsp.valid = 1'h1; // see RULE1
        r_next.rsp.data  = {8'h00, idn_byte(r_reg.idx)};
        r_next.idx       = r_reg.idx + 8'h01;
        if (int'(r_reg.idx) == IDN_LEN - 1)
        begin
          r_next.rsp.last = 1'h1;
          r_next.state    = ccsu_pkg::ST_IDLE;
        end
      end
      ccsu_pkg::ST_OPCW:
      begin
        // the controller must time out longer than the longest operation
        if (!op_busy)
        begin
          r_next.rsp.valid = 1'h1; // see RULE11
          r_next.rsp.last  = 1'h1;
          r_next.rsp.data  = {8'h00, `CCSU_ASCII_ONE};
          r_next.state     = ccsu_pkg::ST_IDLE;
        end
      end
      default:
        r_next.state = ccsu_pkg::ST_IDLE;
    endcase

    if (r_reg.opc_armed && !op_busy && !esr_clr)
    begin
      esr_set[`CCSU_ESR_OPC] = 1'h1; // see RULE10
      r_next.opc_armed       = 1'h0;
    end

    esr_set[`CCSU_ESR_RQC] = esr_set[`CCSU_ESR_RQC] | ev.req_ctrl;
    esr_set[`CCSU_ESR_QYE] = ev.query_err; // see RULE5
    esr_set[`CCSU_ESR_DDE] = ev.dev_err;
    esr_set[`CCSU_ESR_EXE] = ev.exec_err;
    esr_set[`CCSU_ESR_CME] = esr_set[`CCSU_ESR_CME] | ev.cmd_err;
    esr_set[`CCSU_ESR_URQ] = ev.user_req;
    esr_set[`CCSU_ESR_PON] = ev.power_on;

    // a new event in the clearing cycle survives
    r_next.esr = (esr_clr ? 8'h00 : r_reg.esr) | esr_set;
    r_next.qev = (qev_clr ? 16'h0000 : r_reg.qev) | ques_set;
    r_next.oev = (oev_clr ? 16'h0000 : r_reg.oev) | oper_set;

    if (ev.power_on && r_reg.psc)
    begin
      r_next.sre = 8'h00; // see RULE16
      r_next.ese = 8'h00;
      r_next.qen = 16'h0000;
      r_next.oen = 16'h0000;
    end

    // the queue flag lags the clear pulse by the queue's own latency
    stb_low[`CCSU_STB_EAV] = err_queue_nonempty;
    stb_low[`CCSU_STB_QSB] = |(r_next.qev & r_next.qen);
    stb_low[`CCSU_STB_ESB] = |(r_next.esr & r_next.ese); // see RULE6
    stb_low[`CCSU_STB_OSB] = |(r_next.oev & r_next.oen);
    r_next.srq             = |(stb_low & r_next.sre); // see RULE22
    r_next.stb             = stb_low;
    r_next.stb[`CCSU_STB_MSS] = r_next.srq;
    r_next.ready = (r_next.state == ccsu_pkg::ST_IDLE); // see RULE12
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      r_reg <= REGS_RESET;
    else if (ce)
      r_reg <= r_next;
  end

  assign cmd_ready           = r_reg.ready;
  assign rsp                 = r_reg.rsp;
  assign func_reset          = r_reg.func_rst;
  assign err_queue_clear     = r_reg.eq_clr;
  assign summary_status_byte = r_reg.stb;
  assign service_request     = r_reg.srq;

  a_sre_bit_six: assert property ( // see RULE13
    @(posedge clk_sys) disable iff (!nrst)
    !r_reg.sre[6])
    else $error("request enable bit 6 set");

  a_esb_summary_bit: assert property ( // see RULE6
    @(posedge clk_sys) disable iff (!nrst)
    r_reg.stb[5] == |(r_reg.esr & r_reg.ese))
    else $error("status bit 5 not masked event summary");

  a_mss_summary_bit: assert property ( // see RULE22
    @(posedge clk_sys) disable iff (!nrst)
    r_reg.stb[6] == |(r_reg.stb & `CCSU_SRE_MASK & r_reg.sre))
    else $error("status bit 6 not request summary");

  a_opc_wait_block: assert property ( // see RULE12
    @(posedge clk_sys) disable iff (!nrst)
    (r_reg.state == ccsu_pkg::ST_OPCW) |-> !cmd_ready)
    else $error("command accepted during complete query");

  a_opcq_ascii_one: assert property ( // see RULE11
    @(posedge clk_sys) disable iff (!nrst)
    (ce && r_reg.state == ccsu_pkg::ST_OPCW && !op_busy)
      |=> rsp.valid && rsp.data == 16'h0031 && cmd_ready)
    else $error("complete query answer wrong");

  a_ese_keeps_rst: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_RST && !ev.power_on)
      |=> $stable(r_reg.ese) && func_reset)
    else $error("reset command changed event enable");

  a_ese_read_back: assert property ( // see RULE8
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_ESE_R)
      |=> rsp.valid && rsp.data[7:0] == $past(r_reg.ese))
    else $error("event enable readback wrong");

  a_esr_read_clear: assert property ( // see RULE9 see RULE21
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_ESR_R && ev == '0)
      |=> rsp.data[7:0] == $past(r_reg.esr) && r_reg.esr == 8'h00)
    else $error("event register read or clear wrong");

  a_stb_read_kept: assert property ( // see RULE15
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_STB_R)
      |=> rsp.data[7:0] == $past(summary_status_byte))
    else $error("status byte readback wrong");

  a_psc_power_clear: assert property ( // see RULE16
    @(posedge clk_sys) disable iff (!nrst)
    (ce && ev.power_on && r_reg.psc)
      |=> r_reg.sre == 8'h00 && r_reg.ese == 8'h00 && r_reg.esr[7])
    else $error("power-on clear did not act");

  a_tst_answer_bit: assert property ( // see RULE3
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_TST)
      |=> rsp.data == {15'h0000, $past(r_reg.tst_fail)})
    else $error("self-test answer wrong");

  a_cme_unknown_code: assert property ( // see RULE5
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code > `CCSU_CMD_OEN_R)
      |=> r_reg.esr[`CCSU_ESR_CME])
    else $error("unknown code did not flag command error");

  a_qev_read_clear: assert property ( // see RULE19
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_QEV_R && ques_set == 16'h0000)
      |=> rsp.data == $past(r_reg.qev) && r_reg.qev == 16'h0000)
    else $error("questionable event read or clear wrong");

  a_cls_clears_all: assert property ( // see RULE18
    @(posedge clk_sys) disable iff (!nrst)
    (ce && take && cmd.code == `CCSU_CMD_CLS && ev == '0
      && ques_set == 16'h0000 && oper_set == 16'h0000)
      |=> r_reg.esr == 8'h00 && r_reg.qev == 16'h0000
      && r_reg.oev == 16'h0000 && err_queue_clear)
    else $error("clear-status left an event set");

  // a frozen cycle must not even take a pending command
  a_ce_freeze_state: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !ce |=> $stable(r_reg))
    else $error("state moved while clock enable low");

endmodule // ccsu_core

// ===== verification/ccsu_host.sv
// remote controller model driving the command port
`timescale 1ns/1ps
module ccsu_host
(
  input  wire logic                   clk_sys,
  input  wire logic                   cmd_ready,
  input  wire ccsu_pkg::ccsu_rsp_type rsp,
  output      ccsu_pkg::ccsu_cmd_type cmd
);
  // timeout well beyond the longest busy span the bench makes
  localparam int WAIT_MAX = 400;
  logic [15:0] words [$];
  int          n_late = 0;

  initial cmd = '0;

  // request held until the edge that takes it; released lines are inverted
  // so a stale value is never mistaken for a fresh one
  task automatic send(input logic [4:0] code, input logic [15:0] data,
                      input bit ans);
    int n;
    bit got;
    n = 0;
    got = !ans;
    words.delete();
    @(posedge clk_sys);
    #1;
    cmd = '{1'b1, code, data};
    while (cmd_ready !== 1'b1 && n < WAIT_MAX)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1)
      n_late++;
    @(posedge clk_sys);
    #1;
    cmd = '{1'b0, ~code, ~data};
    n = 0;
    while (ans && n < WAIT_MAX)
    begin
      if (rsp.valid === 1'b1)
      begin
        words.push_back(rsp.data);
        if (rsp.last === 1'b1)
        begin
          got = 1'b1;
          break;
        end
      end
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (!got)
      n_late++;
  endtask
endmodule // ccsu_host

// ===== verification/tb.sv
// self-checking bench of the common command and status core
`timescale 1ns/1ps
`include "ccsu_consts.svh"
module tb;
  typedef struct packed {
    logic [4:0]  c;
    logic [15:0] d;
    logic        a;
    logic [15:0] e;
  } ccsu_row_type;
  // identification text; value is arbitrary
  localparam logic [8*22-1:0] IDN_EXP = "ZZCO,BLK7,12345678,0.1";
  logic                     clk_sys;
  logic                     nrst;
  logic                     ce;
  logic                     st_fail;
  ccsu_pkg::ccsu_cmd_type   cmd;
  ccsu_pkg::ccsu_event_type ev;
  logic                     op_busy;
  logic                     q_nonempty;
  logic [15:0]              ques_set;
  logic [15:0]              oper_set;
  logic                     cmd_ready;
  ccsu_pkg::ccsu_rsp_type   rsp;
  logic                     func_reset;
  logic                     err_queue_clear;
  logic [7:0]               stb;
  logic                     srq;
  int                       n_fail, checked, n_rsp, n_frst, n_eqc, rsp_base;
  ccsu_row_type rows [15] = '{
    '{`CCSU_CMD_PSC_R, 16'h0000, 1'h1, 16'h0001},
    '{`CCSU_CMD_TST,   16'h0000, 1'h1, 16'h0000},
    '{`CCSU_CMD_ESE_W, 16'h00A5, 1'h0, 16'h0000},
    '{`CCSU_CMD_ESE_R, 16'h0000, 1'h1, 16'h00A5},
    '{`CCSU_CMD_SRE_W, 16'h00FF, 1'h0, 16'h0000},
    '{`CCSU_CMD_SRE_R, 16'h0000, 1'h1, 16'h00BF},
    '{`CCSU_CMD_RST,   16'h0000, 1'h0, 16'h0000},
    '{`CCSU_CMD_ESE_R, 16'h0000, 1'h1, 16'h00A5},
    '{`CCSU_CMD_QEN_W, 16'hFFFF, 1'h0, 16'h0000},
    '{`CCSU_CMD_QEN_R, 16'h0000, 1'h1, 16'hFFFF},
    '{`CCSU_CMD_OEN_W, 16'h1234, 1'h0, 16'h0000},
    '{`CCSU_CMD_OEN_R, 16'h0000, 1'h1, 16'h1234},
    '{5'h1F,           16'h0000, 1'h0, 16'h0000},
    '{`CCSU_CMD_ESR_R, 16'h0000, 1'h1, 16'h0020},
    '{`CCSU_CMD_ESR_R, 16'h0000, 1'h1, 16'h0000}};

  ccsu_core #(.IDN_LEN(22), .IDN_TEXT(IDN_EXP)) dut
  (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .ce                 (ce),
    .cmd                (cmd),
    .ev                 (ev),
    .op_busy            (op_busy),
    .self_test_fail     (st_fail),
    .err_queue_nonempty (q_nonempty),
    .ques_set           (ques_set),
    .oper_set           (oper_set),
    .cmd_ready          (cmd_ready),
    .rsp                (rsp),
    .func_reset         (func_reset),
    .err_queue_clear    (err_queue_clear),
    .summary_status_byte(stb),
    .service_request    (srq)
  );

  ccsu_host host
  (
    .clk_sys  (clk_sys),
    .cmd_ready(cmd_ready),
    .rsp      (rsp),
    .cmd      (cmd)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    n_rsp  += (rsp.valid === 1'b1);
    n_frst += (func_reset === 1'b1);
    n_eqc  += (err_queue_clear === 1'b1);
  end

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic q(input logic [4:0] c, input logic [15:0] e);
    host.send(c, 16'h0000, 1'b1);
    check("answer", host.words[0], e);
  endtask

  // event inputs are single-cycle pulses
  task automatic pulse(input logic [6:0] e, input logic [15:0] qs, os);
    ev = e;
    ques_set = qs;
    oper_set = os;
    @(posedge clk_sys);
    #1;
    ev = '0;
    ques_set = '0;
    oper_set = '0;
    settle();
  endtask

  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    {nrst, st_fail, op_busy, q_nonempty, ev, ques_set, oper_set} = '0;
    ce = 1'b1;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    check("ready in reset", {15'h0000, cmd_ready}, 16'h0000);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      host.send(rows[i].c, rows[i].d, rows[i].a);
      if (rows[i].a)
        check("row", host.words[0], rows[i].e);
    end
    check("reset pulses", 16'(n_frst), 16'h0001);
    host.send(`CCSU_CMD_IDN, 16'h0000, 1'b1);
    check("idn length", 16'(host.words.size()), 16'h0016);
    for (int i = 0; i < 22; i++)
      check("idn byte", host.words[i],
            {8'h00, IDN_EXP[8*(21-i)+:8]});
    for (int i = 1; i < 7; i++)
    begin
      pulse(7'(1 << (i - 1)), 16'h0000, 16'h0000);
      q(`CCSU_CMD_ESR_R, 16'(1 << i));
    end
    host.send(`CCSU_CMD_SRE_W, 16'h0020, 1'b0);
    q_nonempty = 1'b1;
    pulse(7'h10, 16'h0000, 16'h0000);
    check("status", {8'h00, stb}, 16'h0064);
    check("request", {15'h0000, srq}, 16'h0001);
    q(`CCSU_CMD_STB_R, 16'h0064);
    q(`CCSU_CMD_STB_R, 16'h0064);
    host.send(`CCSU_CMD_CLS, 16'h0000, 1'b0);
    q_nonempty = 1'b0;
    q(`CCSU_CMD_ESR_R, 16'h0000);
    check("queue clear", 16'(n_eqc), 16'h0001);
    pulse(7'h04, 16'h0000, 16'h0000);
    check("masked event", {8'h00, stb}, 16'h0000);
    pulse(7'h00, 16'h8001, 16'h0004);
    check("summaries", {8'h00, stb}, 16'h0088);
    q(`CCSU_CMD_QEV_R, 16'h8001);
    q(`CCSU_CMD_QEV_R, 16'h0000);
    q(`CCSU_CMD_OEV_R, 16'h0004);
    host.send(`CCSU_CMD_CLS, 16'h0000, 1'b0);
    q(`CCSU_CMD_OEV_R, 16'h0000);
    host.send(`CCSU_CMD_ESE_W, 16'h0001, 1'b0);
    op_busy = 1'b1;
    host.send(`CCSU_CMD_OPC, 16'h0000, 1'b0);
    settle();
    check("opc busy", {15'h0000, stb[5]}, 16'h0000);
    op_busy = 1'b0;
    settle();
    check("opc done", {15'h0000, stb[5]}, 16'h0001);
    q(`CCSU_CMD_ESR_R, 16'h0001);
    op_busy = 1'b1;
    fork
      host.send(`CCSU_CMD_OPC_Q, 16'h0000, 1'b1);
      begin
        // the previous answer is counted only at the next edge
        repeat (2) @(posedge clk_sys);
        #1;
        rsp_base = n_rsp;
        repeat (8) @(posedge clk_sys);
        #1;
        check("opcq blocks", {15'h0000, cmd_ready}, 16'h0000);
        check("opcq early", 16'(n_rsp), 16'(rsp_base));
        op_busy = 1'b0;
      end
    join
    check("opcq answer", host.words[0], 16'h0031);
    pulse(7'h40, 16'h0000, 16'h0000);
    q(`CCSU_CMD_ESE_R, 16'h0000);
    q(`CCSU_CMD_SRE_R, 16'h0000);
    q(`CCSU_CMD_ESR_R, 16'h0080);
    host.send(`CCSU_CMD_PSC_W, 16'h0000, 1'b0);
    host.send(`CCSU_CMD_ESE_W, 16'h0011, 1'b0);
    pulse(7'h40, 16'h0000, 16'h0000);
    q(`CCSU_CMD_ESE_R, 16'h0011);
    q(`CCSU_CMD_PSC_R, 16'h0000);
    nrst = 1'b0;
    st_fail = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("ready in reset", {15'h0000, cmd_ready}, 16'h0000);
    check("status in reset", {8'h00, stb}, 16'h0000);
    nrst = 1'b1;
    q(`CCSU_CMD_TST, 16'h0001);
    q(`CCSU_CMD_PSC_R, 16'h0001);
    ce = 1'b0;
    host.send(`CCSU_CMD_ESE_W, 16'h005A, 1'b0);
    ce = 1'b1;
    q(`CCSU_CMD_ESE_R, 16'h0000);
    check("host timeouts", 16'(host.n_late), 16'h0000);
    complete_run();
  end
endmodule // tb
